// ==== wdt_pkg.sv ====
// ==========================================================
// watchdog constants
package wdt_pkg;
   // ==========================================================
   // special function register map
   localparam logic [7:0] WDT_CTRL_ADDR  = 8'hc0;
   localparam int         WDT_PRE_LSB    = 4;
   localparam int         WDT_DIR_BIT    = 3;
   localparam int         WDT_FLAG_BIT   = 2;
   localparam int         WDT_RUN_BIT    = 1;
   localparam int         WDT_UNLOCK_BIT = 0;

   // ==========================================================
   // values after reset
   localparam logic [3:0] WDT_PRE_RST  = 4'h7;
   localparam logic       WDT_DIR_RST  = 1'b0;
   localparam logic       WDT_FLAG_RST = 1'b0;
   localparam logic       WDT_RUN_RST  = 1'b1;

   // ==========================================================
   // timeout select codes
   localparam logic [3:0] WDT_PRE_MAX_TIMED = 4'h7;
   localparam logic [3:0] WDT_PRE_NOW_RST   = 4'h8;
   localparam logic [3:0] WDT_PRE_DL_RST    = 4'h9;
   localparam int         WDT_BASE_SHIFT    = 9;

   // ==========================================================
   // counter input clock, counter width, vector and read reset value
   localparam int         WDT_XTAL_HZ      = 32768;
   localparam int         WDT_CNT_W        = 16;
   localparam logic [15:0] WDT_VECTOR      = 16'h005b;
   localparam logic [7:0] WDT_RDATA_RST    = 8'h00;
endpackage : wdt_pkg

// ==== wdt_unit.sv ====
`timescale 1ns/10ps

module wdt_unit
   import wdt_pkg::*;
#(
   parameter int CNT_W = WDT_CNT_W
) (
   input  wire logic        mclk,
   input  wire logic        srst,
   input  wire logic        ce,
   input  wire logic        crystal_in_pin,
   input  wire logic        lock_protection_flash_bit,
   input  wire logic [7:0]  sfr_addr,
   input  wire logic        sfr_wr,
   input  wire logic [7:0]  sfr_wdata,
   input  wire logic        sfr_rd,
   output logic [7:0]       sfr_rdata,
   output logic             wdt_sys_rst,
   output logic             wdt_dl_rst,
   output logic             watchdog_interrupt_source,
   output logic [15:0]      wdt_vector
);
   import wdt_pkg::*;

   // ==========================================================
   // block notes
   // counter ticks on synced crystal rising edges only
   // crystal edge seen two to three mclk late
   // ce low freezes synchronisers, fields and counter
   // a crystal edge during a freeze may land as one tick
   // unlock arm is consumed by the next write of any address
   // an armed write that is not to the control byte disarms
   // the arming write itself changes no field
   // the accepted write does not re-arm the unlock
   // the unlock bit always reads back as zero
   // run bit written 1 restarts the count from zero
   // run bit written 0 stops and holds the count when unprotected
   // rewriting run 1 is the only way to re-arm in time
   // codes 8 and 9 act once, at the accepted write
   // codes 8 and 9 act whatever the run bit says
   // codes 10 to 15 hold the count, nothing expires
   // a timed code written with run 1 restarts a held count from zero
   // expiry restarts the count, so timeouts repeat
   // limit is one below a power of two of ticks
   // code 7 needs the full 16-bit count
   // flag set on expiry wins over a same-cycle clear
   // writing 1 to the flag bit leaves it as it is
   // srst or a written 0 clears the flag, our reset pulse does not
   // protection pins response 0 and run 1 every cycle
   // select field stays writable under protection
   // protection follows the flash bit two edges late
   // unprotected after srst until the synchroniser fills
   // interrupt is a one-cycle request
   // the core stacks the pc and jumps to the vector
   // vector is a constant, registered for a clean output
   // reset pulses must not feed back into srst
   // read data holds until the next read strobe
   // reads of other addresses return zero
   // all outputs come straight from flops
   // no wait states on writes or reads

   // ==========================================================
   // helper functions
   // last count before expiry for a timed select code
   function automatic logic [CNT_W:0] wdt_limit(input logic [3:0] pre);
      logic [CNT_W:0] one;
      logic [4:0]     sh;
      one = {{CNT_W{1'b0}}, 1'b1};
      sh  = 5'(pre) + 5'(WDT_BASE_SHIFT);        // code 7 needs 16, past 4 bits
      wdt_limit = (one << sh) - one;
   endfunction : wdt_limit

   // select field of a control byte
   function automatic logic [3:0] wdt_sel(input logic [7:0] d);
      wdt_sel = d[WDT_PRE_LSB +: 4];
   endfunction : wdt_sel

   // address decode for the control register
   function automatic logic wdt_is_ctrl(input logic [7:0] a);
      wdt_is_ctrl = (a == WDT_CTRL_ADDR);
   endfunction : wdt_is_ctrl

   // ==========================================================
   // crystal clock synchroniser and edge detect
   logic xtal_s1_r;
   logic xtal_s2_r;
   logic xtal_s3_r;
   logic xtal_tick;

   // two flops, then a third for edge detection
   always_ff @(posedge mclk) begin
      if (srst) begin
         xtal_s1_r <= 1'b0;
         xtal_s2_r <= 1'b0;
         xtal_s3_r <= 1'b0;
      end else if (ce) begin
         xtal_s1_r <= crystal_in_pin;
         xtal_s2_r <= xtal_s1_r;
         xtal_s3_r <= xtal_s2_r;
      end
   end

   assign xtal_tick = xtal_s2_r & ~xtal_s3_r;    // rising edge

   // ==========================================================
   // flash protection synchroniser
   logic prot_s1_r;
   logic prot_s2_r;
   logic prot_on;

   // unprogrammed flash bit reads 1, so idle is unprotected
   always_ff @(posedge mclk) begin
      if (srst) begin
         prot_s1_r <= 1'b1;
         prot_s2_r <= 1'b1;
      end else if (ce) begin
         prot_s1_r <= lock_protection_flash_bit;
         prot_s2_r <= prot_s1_r;
      end
   end

   assign prot_on = ~prot_s2_r;                   // active when cleared

   // ==========================================================
   // write decode and unlock
   logic ctrl_hit;
   logic unlock_r;
   logic ctrl_wr_ok;

   assign ctrl_hit   = sfr_wr & wdt_is_ctrl(sfr_addr);
   assign ctrl_wr_ok = ctrl_hit & unlock_r;

   // arm on a write carrying the unlock bit, any next write disarms
   always_ff @(posedge mclk) begin
      if (srst) begin
         unlock_r <= 1'b0;
      end else if (ce && sfr_wr) begin
         unlock_r <= ctrl_hit & ~unlock_r & sfr_wdata[WDT_UNLOCK_BIT];
      end
   end

   // ==========================================================
   // control register fields
   logic [3:0] pre_r;
   logic       dir_r;
   logic       run_r;
   logic       flag_r;

   // timeout select field
   always_ff @(posedge mclk) begin
      if (srst) begin
         pre_r <= WDT_PRE_RST;
      end else if (ce && ctrl_wr_ok) begin
         pre_r <= wdt_sel(sfr_wdata);
      end
   end

   // response select, pinned low under protection
   always_ff @(posedge mclk) begin
      if (srst) begin
         dir_r <= WDT_DIR_RST;
      end else if (ce) begin
         if (prot_on) begin
            dir_r <= 1'b0;
         end else if (ctrl_wr_ok) begin
            dir_r <= sfr_wdata[WDT_DIR_BIT];
         end
      end
   end

   // run bit, pinned high under protection
   always_ff @(posedge mclk) begin
      if (srst) begin
         run_r <= WDT_RUN_RST;
      end else if (ce) begin
         if (prot_on) begin
            run_r <= 1'b1;
         end else if (ctrl_wr_ok) begin
            run_r <= sfr_wdata[WDT_RUN_BIT];
         end
      end
   end

   // ==========================================================
   // counter and expiry
   logic [CNT_W-1:0] cnt_r;
   logic             timed_code;
   logic             count_en;
   logic             at_limit;
   logic             expire;
   logic             restart;

   // codes 0 to 7 run, codes above hold the count
   assign timed_code = (pre_r <= WDT_PRE_MAX_TIMED);
   // accepted write with the run bit set
   assign restart    = ctrl_wr_ok & sfr_wdata[WDT_RUN_BIT];
   // one step per crystal tick while running a timed code
   assign count_en   = run_r & timed_code & xtal_tick;
   // last count of the selected period
   assign at_limit   = ({1'b0, cnt_r} == wdt_limit(pre_r));
   // expiry on the tick at the limit, a restart wins
   assign expire     = count_en & at_limit & ~restart;

   // count crystal ticks; invalid codes hold the count
   always_ff @(posedge mclk) begin
      if (srst) begin
         cnt_r <= '0;
      end else if (ce) begin
         if (restart || expire) begin
            cnt_r <= '0;
         end else if (count_en) begin
            cnt_r <= cnt_r + 1'b1;
         end
      end
   end

   // status flag: expiry beats a software clear
   always_ff @(posedge mclk) begin
      if (srst) begin
         flag_r <= WDT_FLAG_RST;
      end else if (ce) begin
         if (expire) begin
            flag_r <= 1'b1;
         end else if (ctrl_wr_ok && !sfr_wdata[WDT_FLAG_BIT]) begin
            flag_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // response outputs
   logic [3:0] wr_sel;
   logic       now_rst;
   logic       dl_req;

   // select code carried by an accepted write
   assign wr_sel  = wdt_sel(sfr_wdata);
   assign now_rst = ctrl_wr_ok & (wr_sel == WDT_PRE_NOW_RST);
   assign dl_req  = ctrl_wr_ok & (wr_sel == WDT_PRE_DL_RST);

   // system reset on expiry with response 0, or immediate code
   always_ff @(posedge mclk) begin
      if (srst) begin
         wdt_sys_rst <= 1'b0;
      end else if (ce) begin
         wdt_sys_rst <= (expire & ~dir_r) | now_rst;
      end
   end

   // serial download reset on code 9
   always_ff @(posedge mclk) begin
      if (srst) begin
         wdt_dl_rst <= 1'b0;
      end else if (ce) begin
         wdt_dl_rst <= dl_req;
      end
   end

   // interrupt request on expiry with response 1
   always_ff @(posedge mclk) begin
      if (srst) begin
         watchdog_interrupt_source <= 1'b0;
      end else if (ce) begin
         watchdog_interrupt_source <= expire & dir_r;
      end
   end

   // vector the core loads for this source
   always_ff @(posedge mclk) begin
      if (srst) begin
         wdt_vector <= WDT_VECTOR;
      end else if (ce) begin
         wdt_vector <= WDT_VECTOR;
      end
   end

   // ==========================================================
   // read path
   // unlock bit reads back as zero
   always_ff @(posedge mclk) begin
      if (srst) begin
         sfr_rdata <= WDT_RDATA_RST;
      end else if (ce && sfr_rd) begin
         if (wdt_is_ctrl(sfr_addr)) begin
            sfr_rdata <= {pre_r, dir_r, flag_r, run_r, 1'b0};
         end else begin
            sfr_rdata <= WDT_RDATA_RST;
         end
      end
   end

endmodule : wdt_unit

// ==== wdt_assertions.sv ====
`timescale 1ns/10ps
// ====================
// port checker
module wdt_chk
   import wdt_pkg::*;
#(
   parameter int CNT_W = WDT_CNT_W
) (
   input wire logic        mclk,
   input wire logic        srst,
   input wire logic        ce,
   input wire logic        crystal_in_pin,
   input wire logic        lock_protection_flash_bit,
   input wire logic [7:0]  sfr_addr,
   input wire logic        sfr_wr,
   input wire logic [7:0]  sfr_wdata,
   input wire logic        sfr_rd,
   input wire logic [7:0]  sfr_rdata,
   input wire logic        wdt_sys_rst,
   input wire logic        wdt_dl_rst,
   input wire logic        watchdog_interrupt_source,
   input wire logic [15:0] wdt_vector
);
   logic arm_r;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   // unlock tracker
   always_ff @(posedge mclk) begin
      if (srst) arm_r <= 1'b0;
      else if (ce && sfr_wr) arm_r <= !arm_r && sfr_addr == WDT_CTRL_ADDR && sfr_wdata[0];
   end
   a_vector_fixed: assert property (wdt_vector == WDT_VECTOR)
      else $error("bad vector");
   a_reset_pulse: assert property (wdt_sys_rst && ce |=> !wdt_sys_rst)
      else $error("long reset");
   a_irq_pulse: assert property (watchdog_interrupt_source && ce |=> !watchdog_interrupt_source)
      else $error("long irq");
   a_dl_pulse: assert property (wdt_dl_rst && ce |=> !wdt_dl_rst)
      else $error("long download");
   a_other_zero: assert property (
      ce && sfr_rd && sfr_addr != WDT_CTRL_ADDR |=> sfr_rdata == 8'h00) else $error("bad read");
   a_rdata_held: assert property (!(ce && sfr_rd) |=> $stable(sfr_rdata))
      else $error("read data moved");
   a_lock_forced: assert property (
      (!lock_protection_flash_bit && ce)[*4] ##0 (sfr_rd && sfr_addr == WDT_CTRL_ADDR)
      |=> !sfr_rdata[3] && sfr_rdata[1]) else $error("lock not forcing");
   a_now_reset: assert property (
      ce && sfr_wr && arm_r && sfr_addr == WDT_CTRL_ADDR && sfr_wdata[7:4] == WDT_PRE_NOW_RST
      |=> wdt_sys_rst) else $error("no immediate reset");
   c_reset: cover property (wdt_sys_rst);
   c_irq: cover property (watchdog_interrupt_source);
   c_dl: cover property (wdt_dl_rst);
endmodule : wdt_chk
bind wdt_unit wdt_chk #(.CNT_W(CNT_W)) u_chk (.mclk, .srst, .ce, .crystal_in_pin,
   .lock_protection_flash_bit, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata,
   .wdt_sys_rst, .wdt_dl_rst, .watchdog_interrupt_source, .wdt_vector);

// ==== wdt_core_model.sv ====
`timescale 1ns/10ps
// ====================
// core side: register access and sped-up crystal
module wdt_core_model
   import wdt_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       xrun,
   input  wire logic [7:0] sfr_rdata,
   output logic [7:0]      sfr_addr,
   output logic            sfr_wr,
   output logic [7:0]      sfr_wdata,
   output logic            sfr_rd,
   output logic            crystal_in_pin
);
   int cnt = 0;
   initial {sfr_addr, sfr_wr, sfr_wdata, sfr_rd, crystal_in_pin} = '0;
   // crystal, period 8 clocks, low while stopped
   always @(posedge mclk) begin
      cnt <= (xrun && cnt < 3) ? cnt + 1 : 0;
      if (!xrun) crystal_in_pin <= 1'b0;
      else if (cnt == 3) crystal_in_pin <= !crystal_in_pin;
   end
   // one write strobe, bus shows garbage after
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      {sfr_addr, sfr_wdata, sfr_wr} <= {a, d, 1'b1};
      @(posedge mclk);
      {sfr_addr, sfr_wdata, sfr_wr} <= {~a, ~d, 1'b0};
   endtask : wr
   // arm, then the value write right after
   task automatic set_ctrl(input logic [7:0] d);
      wr(WDT_CTRL_ADDR, 8'h01);
      wr(WDT_CTRL_ADDR, d);
   endtask : set_ctrl
   // read strobe, data taken one cycle later
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(posedge mclk);
      {sfr_addr, sfr_rd} <= {a, 1'b1};
      @(posedge mclk);
      {sfr_addr, sfr_rd} <= {~a, 1'b0};
      @(posedge mclk);
      q = sfr_rdata;
   endtask : rd
endmodule : wdt_core_model

// ==== tb_wdt_unit.sv ====
`timescale 1ns/10ps
// ====================
// watchdog bench
module tb_wdt_unit
   import wdt_pkg::*;
;
   logic        mclk = 1'b0;
   logic        srst = 1'b1;
   logic        lock = 1'b1;
   logic        ce   = 1'b1;
   logic        xrun = 1'b0;
   logic        sfr_wr, sfr_rd, crystal_in_pin, sys_rst, dl_rst, irq;
   logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, q;
   logic [15:0] vec;
   wire  [2:0]  ev = {dl_rst, irq, sys_rst};
   int          mismatches = 0;
   int          num_checks = 0;
   int          n;
   always #2.5 mclk = !mclk;
   wdt_core_model u_core (.mclk, .xrun, .sfr_rdata, .sfr_addr, .sfr_wr, .sfr_wdata,
      .sfr_rd, .crystal_in_pin);
   wdt_unit dut (.mclk, .srst, .ce, .crystal_in_pin, .lock_protection_flash_bit(lock),
      .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata, .wdt_sys_rst(sys_rst),
      .wdt_dl_rst(dl_rst), .watchdog_interrupt_source(irq), .wdt_vector(vec));
   task automatic stop_test;
      if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // cycles until pulse sel (0 reset, 1 irq, 2 download)
   task automatic wait_ev(input int sel, input int lim);
      #1;
      for (n = 0; n < lim && ev[sel] !== 1'b1; n++) @(posedge mclk) #1;
      if (n == lim) begin
         mismatches++;
         stop_test();
      end
   endtask : wait_ev
   task automatic quiet(input int lim);
      logic [2:0] seen;
      seen = '0;
      repeat (lim) begin
         @(posedge mclk);
         #1 seen |= ev;
      end
      chk(seen, 3'h0);
   endtask : quiet
   task automatic t_misc;
      u_core.rd(WDT_CTRL_ADDR, q);
      chk(q, 8'h72);
      chk(vec, WDT_VECTOR);
      u_core.rd(8'hc1, q);
      chk(q, 8'h00);
      u_core.wr(WDT_CTRL_ADDR, 8'h30);
      u_core.wr(WDT_CTRL_ADDR, 8'h01);
      u_core.wr(8'hc1, 8'h00);
      u_core.wr(WDT_CTRL_ADDR, 8'h30);
      u_core.rd(WDT_CTRL_ADDR, q);
      chk(q, 8'h72);
   endtask : t_misc
   task automatic t_expire;
      u_core.set_ctrl(8'h02);
      wait_ev(0, 20000);
      chk(n > 4080 && n < 4112, 1'b1);
      u_core.rd(WDT_CTRL_ADDR, q);
      chk(q, 8'h06);
      u_core.set_ctrl(8'h1a);
      wait_ev(1, 20000);
      chk(n > 8176 && n < 8208, 1'b1);
      u_core.rd(WDT_CTRL_ADDR, q);
      chk(q, 8'h1e);
   endtask : t_expire
   task automatic t_stop;
      u_core.set_ctrl(8'h00);
      quiet(9000);
      u_core.rd(WDT_CTRL_ADDR, q);
      chk(q, 8'h00);
      repeat (3) begin
         u_core.set_ctrl(8'h02);
         quiet(3000);
      end
      u_core.set_ctrl(8'h80);
      wait_ev(0, 4);
      chk(n < 2, 1'b1);
      u_core.set_ctrl(8'h90);
      wait_ev(2, 4);
      chk(n < 2, 1'b1);
      u_core.set_ctrl(8'ha2);
      quiet(9000);
   endtask : t_stop
   task automatic t_freeze;
      u_core.set_ctrl(8'h02);
      @(posedge mclk) ce <= 1'b0;
      quiet(6000);
      @(posedge mclk) ce <= 1'b1;
      wait_ev(0, 5000);
      chk(n > 4070 && n < 4112, 1'b1);
      u_core.rd(WDT_CTRL_ADDR, q);
      chk(q, 8'h06);
      @(posedge mclk) srst <= 1'b1;
      repeat (4) @(posedge mclk);
      srst <= 1'b0;
      u_core.rd(WDT_CTRL_ADDR, q);
      chk(q, 8'h72);
   endtask : t_freeze
   task automatic t_prot;
      @(posedge mclk) lock <= 1'b0;
      repeat (3) @(posedge mclk);
      u_core.set_ctrl(8'h08);
      u_core.rd(WDT_CTRL_ADDR, q);
      chk(q, 8'h02);
      wait_ev(0, 5000);
   endtask : t_prot
   initial begin
      repeat (4) @(posedge mclk);
      srst <= 1'b0;
      xrun <= 1'b1;
      t_misc();
      t_expire();
      t_stop();
      t_freeze();
      t_prot();
      stop_test();
   end
endmodule : tb_wdt_unit
